//--- rtl/fspc_device.sv
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module fspc_device #(
   parameter int PANELS    = 1,
   parameter int OP_CNT    = fspc_pkg::OP_CYCLES
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // core side
   fspc_if.device    bus
);
   import fspc_pkg::*;
   localparam int DEPTH = PANELS * PANEL_ROWS * ROW_WORDS;
   localparam int AW    = $clog2(DEPTH);

   logic [WORD_W-1:0]  flash   [DEPTH];
   logic [WORD_W-1:0]  latch   [ROW_WORDS];
   logic [15:0]        control;
   logic [15:0]        addr_low;
   logic [7:0]         addr_high;
   logic [7:0]         table_page;
   logic               key_armed;
   logic               unlocked;
   fspc_state_t        state;
   logic [CNT_W-1:0]   count;
   logic [15:0]        rdata;
   logic               stall;

   wire logic [ADDR_W-1:0] full_addr = {table_page, bus.tbl_ea};
   wire logic [ROW_IDX_W-1:0] word_idx = full_addr[ROW_IDX_W:1];
   wire logic [AW-1:0] rd_idx  = full_addr[AW:1];
   // row-aligned word index of the target, cut to the array depth
   wire logic [ADDR_W-2:0] row_word = {addr_high, addr_low[15:ROW_IDX_W+1], {ROW_IDX_W{1'b0}}};
   wire logic [AW-1:0] row_base = row_word[AW-1:0];
   wire logic start_wr = bus.reg_write && bus.reg_addr == REG_CONTROL && bus.reg_wdata[CTL_START_BIT];
   wire logic tbl_store = bus.tbl_valid && bus.tbl_write && state == FSPC_IDLE;
   // one decision for sequencer, stall and control so they never disagree
   wire logic start_ok  = start_wr && unlocked && control[CTL_ENABLE_BIT] && !tbl_store && state == FSPC_IDLE;

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state <= FSPC_IDLE;
         count <= '0;
      end else begin
         case (state)
            FSPC_IDLE: begin
               if (tbl_store) begin
                  state <= FSPC_STORE;
                  count <= CNT_W'(STORE_CYCLES - 1);
               end else if (start_ok) begin
                  state <= FSPC_BUSY;
                  count <= CNT_W'(OP_CNT - 1);
               end
            end
            FSPC_STORE: begin
               if (count == '0 || count == CNT_W'(1)) state <= FSPC_IDLE;
               count <= '0;
            end
            FSPC_BUSY: begin
               if (count == '0) state <= FSPC_IDLE;
               else count <= count - CNT_W'(1);
            end
            default: state <= FSPC_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // core stall
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         stall <= 1'b0;
      end else begin
         stall <= (state == FSPC_BUSY && count != '0) ||
                  start_ok;
      end
   end
   assign bus.stall = stall;

   // ----------------------------------------
   // unlock key tracking
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         key_armed <= 1'b0;
         unlocked  <= 1'b0;
      end else if (bus.reg_write) begin
         if (bus.reg_addr == REG_UNLOCK) begin
            key_armed <= bus.reg_wdata[7:0] == KEY_FIRST;
            unlocked  <= key_armed && bus.reg_wdata[7:0] == KEY_SECOND;
         // any other write drops the pair
         end else begin
            key_armed <= 1'b0;
            unlocked  <= 1'b0;
         end
      end else if (tbl_store) begin
         key_armed <= 1'b0;
         unlocked  <= 1'b0;
      end
   end

   // ----------------------------------------
   // control register
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         control <= CTL_RESET;
      end else if (state == FSPC_BUSY && count == '0) begin
         control[CTL_START_BIT] <= 1'b0;
      end else if (bus.reg_write && bus.reg_addr == REG_CONTROL && state == FSPC_IDLE) begin
         control <= bus.reg_wdata & CTL_WR_MASK;
         control[CTL_START_BIT] <= start_ok;
         control[CTL_ERROR_BIT] <= start_wr && !start_ok;
      end
   end

   // ----------------------------------------
   // address and page registers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         addr_low   <= 16'h0000;
         addr_high  <= 8'h00;
         table_page <= 8'h00;
      end else if (bus.tbl_valid && state == FSPC_IDLE) begin
         addr_low  <= bus.tbl_ea;
         addr_high <= table_page;
      end else if (bus.reg_write && state == FSPC_IDLE) begin
         if (bus.reg_addr == REG_ADDR_LOW)   addr_low   <= bus.reg_wdata;
         if (bus.reg_addr == REG_ADDR_HIGH)  addr_high  <= bus.reg_wdata[7:0];
         if (bus.reg_addr == REG_TABLE_PAGE) table_page <= bus.reg_wdata[7:0];
      end
   end

   // ----------------------------------------
   // write latches
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (tbl_store) begin
         if (!bus.tbl_high)
            latch[word_idx][15:0] <= fspc_merge(latch[word_idx][15:0], bus.tbl_wdata,
                                                bus.tbl_byte, bus.tbl_ea[0]);
         else
            latch[word_idx][23:16] <= bus.tbl_wdata[7:0];
      end
   end

   // ----------------------------------------
   // flash array, row at a time
   // ----------------------------------------
   always_ff @(posedge clk) begin
      // commit one row at end of operation
      if (state == FSPC_BUSY && count == '0) begin
         for (int i = 0; i < ROW_WORDS; i++) begin
            if (control[CTL_OP_BIT])
               flash[row_base + AW'(i)] <= {WORD_W{1'b1}};
            else
               flash[row_base + AW'(i)] <= latch[i];
         end
      end
   end

   // ----------------------------------------
   // read port
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rdata <= 16'h0000;
      end else if (bus.tbl_valid && !bus.tbl_write) begin
         rdata <= bus.tbl_high ? {8'h00, flash[rd_idx][23:16]} : flash[rd_idx][15:0];
      end else if (bus.reg_read) begin
         case (bus.reg_addr)
            REG_CONTROL:    rdata <= control;
            REG_ADDR_LOW:   rdata <= addr_low;
            REG_ADDR_HIGH:  rdata <= {8'h00, addr_high};
            REG_TABLE_PAGE: rdata <= {8'h00, table_page};
            default:        rdata <= 16'h0000;
         endcase
      end
   end
   assign bus.rdata = rdata;
endmodule

//--- include/fspc_pkg.sv
package fspc_pkg;
   // ----------------------------------------
   // geometry
   // ----------------------------------------
   localparam int ROW_WORDS       = 32;
   localparam int ROW_BYTES       = 96;
   localparam int PANEL_ROWS      = 128;
   localparam int ROW_IDX_W       = 5;
   localparam int ADDR_W          = 24;
   localparam int WORD_W          = 24;
   // ----------------------------------------
   // register offsets on the device port
   // ----------------------------------------
   localparam logic [3:0] REG_CONTROL   = 4'h0;
   localparam logic [3:0] REG_ADDR_LOW  = 4'h2;
   localparam logic [3:0] REG_ADDR_HIGH = 4'h4;
   localparam logic [3:0] REG_UNLOCK    = 4'h6;
   localparam logic [3:0] REG_TABLE_PAGE = 4'h8;
   // ----------------------------------------
   // control register fields
   // ----------------------------------------
   localparam int CTL_START_BIT   = 15;
   localparam int CTL_ENABLE_BIT  = 14;
   localparam int CTL_ERROR_BIT   = 13;
   localparam int CTL_OP_BIT      = 6;
   localparam int CTL_TYPE_LO     = 0;
   localparam int CTL_TYPE_HI     = 3;
   localparam logic [15:0] CTL_RESET     = 16'h0000;
   localparam logic [15:0] CTL_WR_MASK   = 16'h407f;
   localparam logic [3:0]  TYPE_ROW_PROG = 4'h1;
   // ----------------------------------------
   // unlock keys and timing
   // ----------------------------------------
   localparam logic [7:0] KEY_FIRST  = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'haa;
   localparam int CLK_MHZ      = 100;
   localparam int OP_TIME_US   = 2000;
   localparam int OP_CYCLES    = OP_TIME_US * CLK_MHZ;
   localparam int STORE_CYCLES = 2;
   localparam int CNT_W        = 18;
   // ----------------------------------------
   // host command port
   // ----------------------------------------
   localparam logic [3:0] CMD_STATUS  = 4'h0;
   localparam logic [3:0] CMD_ADDR    = 4'h1;
   localparam logic [3:0] CMD_DATA    = 4'h2;
   localparam logic [3:0] CMD_ACTION  = 4'h3;
   localparam logic [3:0] CMD_RDATA   = 4'h4;
   localparam logic [2:0] ACT_STORE_LOW  = 3'h0;
   localparam logic [2:0] ACT_STORE_HIGH = 3'h1;
   localparam logic [2:0] ACT_READ_LOW   = 3'h2;
   localparam logic [2:0] ACT_READ_HIGH  = 3'h3;
   localparam logic [2:0] ACT_REG_WRITE  = 3'h4;
   localparam logic [2:0] ACT_REG_READ   = 3'h5;

   typedef enum logic [1:0] {
      FSPC_IDLE  = 2'b00,
      FSPC_STORE = 2'b01,
      FSPC_BUSY  = 2'b10
   } fspc_state_t;

   // byte or word merge into a 16-bit lane
   function automatic logic [15:0] fspc_merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                              input logic byte_mode, input logic odd);
      logic [15:0] r;
      r = new_v;
      if (byte_mode) begin
         r = odd ? {new_v[7:0], old_v[7:0]} : {old_v[15:8], new_v[7:0]};
      end
      return r;
   endfunction
endpackage

//--- include/fspc_if.sv
`timescale 1ns/1ps
interface fspc_if;
   logic        tbl_valid;
   logic        tbl_write;
   logic        tbl_high;
   logic        tbl_byte;
   logic [15:0] tbl_ea;
   logic [15:0] tbl_wdata;
   logic        reg_write;
   logic        reg_read;
   logic [3:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic [15:0] rdata;
   logic        stall;
   modport device (input tbl_valid, tbl_write, tbl_high, tbl_byte, tbl_ea, tbl_wdata,
                   reg_write, reg_read, reg_addr, reg_wdata, output rdata, stall);
   modport core (output tbl_valid, tbl_write, tbl_high, tbl_byte, tbl_ea, tbl_wdata,
                 reg_write, reg_read, reg_addr, reg_wdata, input rdata, stall);
endinterface

//--- rtl/fspc_core.sv
`timescale 1ns/1ps
module fspc_core (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // command port
   input  wire logic [3:0]  cmd_addr,
   input  wire logic [31:0] cmd_wdata,
   input  wire logic        cmd_write,
   input  wire logic        cmd_read,
   output logic [31:0]      cmd_rdata,
   // device side
   fspc_if.core             bus
);
   import fspc_pkg::*;

   logic [15:0] ea;
   logic [15:0] wdata;
   logic [15:0] last_rdata;
   logic        busy;
   logic        pend_read;
   logic        tbl_valid, tbl_write, tbl_high, tbl_byte;
   logic        reg_write, reg_read;
   logic [3:0]  reg_addr;

   // ----------------------------------------
   // command decode to one-cycle actions
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ea <= 16'h0000;
         wdata <= 16'h0000;
         tbl_valid <= 1'b0; tbl_write <= 1'b0; tbl_high <= 1'b0; tbl_byte <= 1'b0;
         reg_write <= 1'b0; reg_read <= 1'b0; reg_addr <= 4'h0;
      end else begin
         tbl_valid <= 1'b0;
         reg_write <= 1'b0;
         reg_read  <= 1'b0;
         if (cmd_write && cmd_addr == CMD_ADDR) ea <= cmd_wdata[15:0];
         if (cmd_write && cmd_addr == CMD_DATA) wdata <= cmd_wdata[15:0];
         if (cmd_write && cmd_addr == CMD_ACTION && !bus.stall) begin
            tbl_byte <= cmd_wdata[3];
            reg_addr <= cmd_wdata[7:4];
            case (cmd_wdata[2:0])
               ACT_STORE_LOW:  begin tbl_valid <= 1'b1; tbl_write <= 1'b1; tbl_high <= 1'b0; end
               ACT_STORE_HIGH: begin tbl_valid <= 1'b1; tbl_write <= 1'b1; tbl_high <= 1'b1; end
               ACT_READ_LOW:   begin tbl_valid <= 1'b1; tbl_write <= 1'b0; tbl_high <= 1'b0; end
               ACT_READ_HIGH:  begin tbl_valid <= 1'b1; tbl_write <= 1'b0; tbl_high <= 1'b1; end
               ACT_REG_WRITE:  reg_write <= 1'b1;
               ACT_REG_READ:   reg_read  <= 1'b1;
               default:        reg_read  <= 1'b0;
            endcase
         end
      end
   end

   assign bus.tbl_valid = tbl_valid;
   assign bus.tbl_write = tbl_write;
   assign bus.tbl_high  = tbl_high;
   assign bus.tbl_byte  = tbl_byte;
   assign bus.tbl_ea    = ea;
   assign bus.tbl_wdata = wdata;
   assign bus.reg_write = reg_write;
   assign bus.reg_read  = reg_read;
   assign bus.reg_addr  = reg_addr;
   assign bus.reg_wdata = wdata;

   // ----------------------------------------
   // status and read capture
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         busy <= 1'b0;
         pend_read <= 1'b0;
         last_rdata <= 16'h0000;
      end else begin
         busy <= bus.stall;
         pend_read <= (tbl_valid && !tbl_write) || reg_read;
         if (pend_read) last_rdata <= bus.rdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cmd_rdata <= 32'h0000_0000;
      end else if (cmd_read) begin
         case (cmd_addr)
            CMD_STATUS: cmd_rdata <= {31'h0000_0000, busy};
            CMD_ADDR:   cmd_rdata <= {16'h0000, ea};
            CMD_DATA:   cmd_rdata <= {16'h0000, wdata};
            CMD_RDATA:  cmd_rdata <= {16'h0000, last_rdata};
            default:    cmd_rdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule

//--- tb/fspc_props.sv
`timescale 1ns/1ps
module fspc_props #(
   parameter int OP_CNT = 50
) (
   // clock and reset
   input wire logic        clk,
   input wire logic        reset_n,
   // carrier signals
   input wire logic        tbl_valid,
   input wire logic        tbl_write,
   input wire logic        tbl_high,
   input wire logic [15:0] tbl_ea,
   input wire logic        reg_write,
   input wire logic        reg_read,
   input wire logic [3:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] rdata,
   input wire logic        stall
);
   import fspc_pkg::*;
   logic [8:0]  w_last;
   logic [8:0]  w_prev;
   logic        st_q;
   logic [15:0] lo;
   logic [7:0]  hi;
   logic [7:0]  pg;
   logic [31:0] cnt;
   logic        acc;
   logic        en_q;
   logic        keys_ok;
   logic        start_req;
   // ----------------------------------------
   // mirrors of what the device must hold
   // ----------------------------------------
   assign acc       = tbl_valid && !stall && !st_q;
   assign keys_ok   = (w_prev == {1'b1, KEY_FIRST}) && (w_last == {1'b1, KEY_SECOND});
   assign start_req = reg_write && !stall && reg_addr == REG_CONTROL && reg_wdata[CTL_START_BIT] && en_q && keys_ok;
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         w_last <= 9'h000;
         w_prev <= 9'h000;
      end else if ((reg_write && !stall) || (acc && tbl_write)) begin
         w_prev <= w_last;
         w_last <= {reg_write && reg_addr == REG_UNLOCK, reg_wdata[7:0]};
      end
   end
   always_ff @(posedge clk) begin
      st_q <= reset_n && acc && tbl_write;
      cnt  <= (reset_n && stall) ? cnt + 32'h1 : 32'h0;
   end
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         lo <= 16'h0000;
         hi <= 8'h00;
         pg <= 8'h00;
         en_q <= 1'b0;
      end else if (acc) begin
         lo <= tbl_ea;
         hi <= pg;
      end else if (reg_write && !stall && !st_q) begin
         if (reg_addr == REG_CONTROL) en_q <= reg_wdata[CTL_ENABLE_BIT];
         if (reg_addr == REG_ADDR_LOW) lo <= reg_wdata;
         if (reg_addr == REG_ADDR_HIGH) hi <= reg_wdata[7:0];
         if (reg_addr == REG_TABLE_PAGE) pg <= reg_wdata[7:0];
      end
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence s_start;
      start_req;
   endsequence
   sequence s_done;
      $fell(stall);
   endsequence
   start_keys_a: assert property ($rose(stall) |-> $past(start_req))
      else $error("stall rose without unlocked start");
   start_go_a: assert property (s_start |=> stall)
      else $error("unlocked start did not stall");
   stall_max_a: assert property (stall |-> cnt <= OP_CNT + 4)
      else $error("operation too long");
   stall_min_a: assert property (s_done |-> $past(cnt) >= OP_CNT - 4)
      else $error("operation too short");
   addr_low_a: assert property (reg_read && !stall && reg_addr == REG_ADDR_LOW |=> rdata == lo)
      else $error("low target address wrong");
   addr_high_a: assert property (reg_read && !stall && reg_addr == REG_ADDR_HIGH |=> rdata == {8'h00, hi})
      else $error("high target address wrong");
   key_read_a: assert property (reg_read && !stall && reg_addr == REG_UNLOCK |=> rdata == 16'h0000)
      else $error("key register readable");
   start_clear_a: assert property (reg_read && !stall && reg_addr == REG_CONTROL |=> !rdata[15])
      else $error("start bit set while idle");
   high_lane_a: assert property (acc && !tbl_write && tbl_high |=> rdata[15:8] == 8'h00)
      else $error("high lane wider than a byte");
endmodule

//--- tb/tb_flash_self_program_ctrl.sv
`timescale 1ns/1ps
module tb_flash_self_program_ctrl;
   import fspc_pkg::*;
   localparam int OPN = 50;
   logic        clk;
   logic        reset_n;
   logic [3:0]  cmd_addr;
   logic [31:0] cmd_wdata;
   logic        cmd_write;
   logic        cmd_read;
   logic [31:0] cmd_rdata;
   logic [31:0] rd;
   int          num_errors;
   int          checks_done;
   int          cyc;
   int          hi_cnt;
   int          i;
   fspc_if bus_if ();
   fspc_device #(.PANELS(1), .OP_CNT(OPN)) u_fspc_device (.clk(clk), .reset_n(reset_n), .bus(bus_if.device));
   fspc_core u_fspc_core (.clk(clk), .reset_n(reset_n), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
      .cmd_write(cmd_write), .cmd_read(cmd_read), .cmd_rdata(cmd_rdata), .bus(bus_if.core));
   fspc_props #(.OP_CNT(OPN)) u_fspc_props (.clk(clk), .reset_n(reset_n), .tbl_valid(bus_if.tbl_valid),
      .tbl_write(bus_if.tbl_write), .tbl_high(bus_if.tbl_high), .tbl_ea(bus_if.tbl_ea),
      .reg_write(bus_if.reg_write), .reg_read(bus_if.reg_read), .reg_addr(bus_if.reg_addr),
      .reg_wdata(bus_if.reg_wdata), .rdata(bus_if.rdata), .stall(bus_if.stall));
   // ----------------------------------------
   // clock, stall length, hang guard
   // ----------------------------------------
   initial clk = 1'b0;
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (bus_if.stall === 1'b1) hi_cnt = hi_cnt + 1;
      if (cyc == 12000) begin
         num_errors = num_errors + 1;
         end_sim();
      end
   end
   // ----------------------------------------
   // end, check and access tasks
   // ----------------------------------------
   task end_sim();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done = checks_done + 1;
      if (got !== exp) begin
         num_errors = num_errors + 1;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task cw(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      cmd_addr  <= a;
      cmd_wdata <= d;
      cmd_write <= 1'b1;
      @(posedge clk);
      cmd_write <= 1'b0;
   endtask
   task cr(input logic [3:0] a);
      @(posedge clk);
      cmd_addr <= a;
      cmd_read <= 1'b1;
      @(posedge clk);
      cmd_read <= 1'b0;
      #1 rd = cmd_rdata;
   endtask
   task act(input logic [2:0] op, input logic [3:0] ra, input logic byt);
      cw(CMD_ACTION, {24'h0, ra, byt, op});
      repeat (4) @(posedge clk);
   endtask
   task dw(input logic [3:0] ra, input logic [15:0] v);
      cw(CMD_DATA, {16'h0, v});
      act(ACT_REG_WRITE, ra, 1'b0);
   endtask
   task dr(input logic [3:0] ra);
      act(ACT_REG_READ, ra, 1'b0);
      cr(CMD_RDATA);
   endtask
   // table access; a read leaves its data in rd
   task tb_op(input logic [2:0] op, input logic [15:0] ea, input logic [15:0] v, input logic byt);
      cw(CMD_ADDR, {16'h0, ea});
      cw(CMD_DATA, {16'h0, v});
      act(op, 4'h0, byt);
      cr(CMD_RDATA);
   endtask
   // unlock and start, optionally breaking the key pair, then wait for idle
   task go(input logic [15:0] ctl, input logic [7:0] k2, input logic brk);
      int j;
      dw(REG_CONTROL, ctl & 16'h7fff);
      dw(REG_UNLOCK, {8'h00, KEY_FIRST});
      if (brk) dw(REG_ADDR_LOW, 16'h6000);
      dw(REG_UNLOCK, {8'h00, k2});
      hi_cnt = 0;
      dw(REG_CONTROL, ctl);
      for (j = 0; j < 300; j++) begin
         cr(CMD_STATUS);
         if (rd[0] === 1'b0) break;
      end
   endtask
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      cyc = 0;
      hi_cnt = 0;
      num_errors = 0;
      checks_done = 0;
      reset_n = 1'b0;
      cmd_addr = 4'h0;
      cmd_wdata = 32'h0;
      cmd_write = 1'b0;
      cmd_read = 1'b0;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      dr(REG_CONTROL);
      chk(rd[15:0], CTL_RESET);
      dw(REG_CONTROL, 16'h7fff);
      dr(REG_CONTROL);
      chk(rd[15:0], 16'h407f);
      dr(REG_UNLOCK);
      chk(rd[15:0], 16'h0000);
      $display("registers done");
      go(16'hc041, 8'h5a, 1'b0);
      chk(hi_cnt[15:0], 16'h0000);
      go(16'hc041, KEY_SECOND, 1'b1);
      chk(hi_cnt[15:0], 16'h0000);
      go(16'h8041, KEY_SECOND, 1'b0);
      chk(hi_cnt[15:0], 16'h0000);
      dr(REG_CONTROL);
      chk(rd[15:0] & 16'ha000, 16'h2000);
      $display("refused starts done");
      dw(REG_ADDR_HIGH, 16'h0001);
      dw(REG_ADDR_LOW, 16'h6000);
      go(16'hc041, KEY_SECOND, 1'b0);
      chk({15'h0, hi_cnt >= OPN - 4 && hi_cnt <= OPN + 4}, 16'h0001);
      dr(REG_CONTROL);
      chk(rd[15:0] & 16'h8000, 16'h0000);
      dw(REG_TABLE_PAGE, 16'h0001);
      tb_op(ACT_READ_LOW, 16'h6010, 16'h0, 1'b0);
      chk(rd[15:0], 16'hffff);
      tb_op(ACT_READ_HIGH, 16'h6010, 16'h0, 1'b0);
      chk(rd[15:0], 16'h00ff);
      dr(REG_ADDR_LOW);
      chk(rd[15:0], 16'h6010);
      dr(REG_ADDR_HIGH);
      chk(rd[15:0], 16'h0001);
      $display("erase done");
      for (i = 0; i < 32; i++) begin
         tb_op(ACT_STORE_LOW, 16'h6000 + 16'(2 * i), 16'h1100 + 16'(i), 1'b0);
         tb_op(ACT_STORE_HIGH, 16'h6000 + 16'(2 * i), 16'h0040 + 16'(i), 1'b0);
      end
      tb_op(ACT_STORE_LOW, 16'h6007, 16'h00ab, 1'b1);
      tb_op(ACT_STORE_LOW, 16'h6008, 16'h00cd, 1'b1);
      tb_op(ACT_READ_LOW, 16'h600a, 16'h0, 1'b0);
      chk(rd[15:0], 16'hffff);
      cr(CMD_ADDR);
      chk(rd[15:0], 16'h600a);
      go(16'hc001, KEY_SECOND, 1'b0);
      chk({15'h0, hi_cnt >= OPN - 4 && hi_cnt <= OPN + 4}, 16'h0001);
      for (i = 0; i < 32; i++) begin
         tb_op(ACT_READ_LOW, 16'h6000 + 16'(2 * i), 16'h0, 1'b0);
         chk(rd[15:0], (i == 3) ? 16'hab03 : (i == 4) ? 16'h11cd : 16'h1100 + 16'(i));
         tb_op(ACT_READ_HIGH, 16'h6000 + 16'(2 * i), 16'h0, 1'b0);
         chk(rd[15:0], 16'h0040 + 16'(i));
      end
      $display("program done");
      end_sim();
   end
endmodule
